// ===== rtl/cfrs_defs.svh
// constants of the cpu flag, register file and stack pointer block
`ifndef CFRS_DEFS_SVH
`define CFRS_DEFS_SVH

// ----------------------------------------------------------------
// flag register layout and reset
// ----------------------------------------------------------------
`define CFRS_SR_I    7
`define CFRS_SR_T    6
`define CFRS_SR_H    5
`define CFRS_SR_S    4
`define CFRS_SR_V    3
`define CFRS_SR_N    2
`define CFRS_SR_Z    1
`define CFRS_SR_C    0
`define CFRS_SR_RST  8'h00
`define CFRS_MSB     7

// ----------------------------------------------------------------
// flag update mask bits
// ----------------------------------------------------------------
`define CFRS_FW_H    4
`define CFRS_FW_V    3
`define CFRS_FW_N    2
`define CFRS_FW_Z    1
`define CFRS_FW_C    0

// ----------------------------------------------------------------
// data space map
// ----------------------------------------------------------------
`define CFRS_RF_TOP  16'h001f
`define CFRS_IO_OFS  16'h0020
`define CFRS_A_SPL   16'h005d
`define CFRS_A_SPH   (`CFRS_A_SPL + 16'h0001)
`define CFRS_A_CPU_FLAG_REGISTER  16'h005f
`define CFRS_PTR_X   5'h1a
`define CFRS_PTR_Y   5'h1c
`define CFRS_PTR_Z   5'h1e

// ----------------------------------------------------------------
// stack pointer
// ----------------------------------------------------------------
`define CFRS_SP_RST  16'h04ff
`define CFRS_SP_MASK 16'h0fff
`define CFRS_ONE     16'h0001
`define CFRS_TWO     16'h0002

`endif

// ===== rtl/cfrs_pkg.sv
// types shared by the cpu flag, register file and stack pointer block
package cfrs_pkg;

  // one operation per cycle from the instruction decoder
  typedef enum logic [3:0] {
    OP_NONE, OP_PUSH, OP_POP, OP_CALL, OP_RET,
    OP_RETURN_FROM_INT_OP, OP_SEI, OP_CLI, OP_BST, OP_BLD
  } cfrs_op_t;

  // indirect pointer selection and addressing mode
  typedef enum logic [1:0] {PS_X, PS_Y, PS_Z} cfrs_psel_t;
  typedef enum logic [1:0] {PM_DISP, PM_INC, PM_DEC} cfrs_pmode_t;

endpackage

// ===== rtl/cfrs_rf_if.sv
// carrier between the core logic and the working register array
`timescale 1ns/1ns
`default_nettype none
interface cfrs_rf_if;
  logic [4:0]  ra, rb, rc;     // read addresses
  logic [7:0]  da, db, dc;     // read data
  logic [15:0] d16;            // pair read at ra
  logic        we;             // byte write
  logic [4:0]  wa;
  logic [7:0]  wd;
  logic        we16;           // pair write
  logic [4:0]  wa16;
  logic [15:0] wd16;
  logic [15:0] px, py, pz;     // pointer pairs

  modport core (output ra, rb, rc, we, wa, wd, we16, wa16, wd16,
                input  da, db, dc, d16, px, py, pz);
  modport store (input  ra, rb, rc, we, wa, wd, we16, wa16, wd16,
                 output da, db, dc, d16, px, py, pz);
endinterface
`default_nettype wire

// ===== rtl/cfrs_regfile.sv
// 32 x 8 working register array with pair access
`timescale 1ns/1ns
`default_nettype none
`include "cfrs_defs.svh"
module cfrs_regfile (
  input wire logic   core_clk, // cpu clock
  cfrs_rf_if.store   rf        // core side
);
  logic [7:0] mem [32];

  // ----------------------------------------------------------------
  // reads: odd register is the high byte of a pair
  // ----------------------------------------------------------------
  assign rf.da  = mem[rf.ra];
  assign rf.db  = mem[rf.rb];
  assign rf.dc  = mem[rf.rc];
  assign rf.d16 = {mem[rf.ra | 5'h01], mem[rf.ra & 5'h1e]};
  assign rf.px  = {mem[`CFRS_PTR_X + 5'h01], mem[`CFRS_PTR_X]};
  assign rf.py  = {mem[`CFRS_PTR_Y + 5'h01], mem[`CFRS_PTR_Y]};
  assign rf.pz  = {mem[`CFRS_PTR_Z + 5'h01], mem[`CFRS_PTR_Z]};

  // writes: a byte write lands after a pair write, so it wins on overlap
  always_ff @(posedge core_clk) begin
    if (rf.we16) begin
      mem[rf.wa16 & 5'h1e] <= rf.wd16[7:0];
      mem[rf.wa16 | 5'h01] <= rf.wd16[15:8];
    end
    if (rf.we) begin
      mem[rf.wa] <= rf.wd;
    end
  end
endmodule // cfrs_regfile
`default_nettype wire

// ===== rtl/cfrs_core.sv
// cpu flag register, working register file access and stack pointer
`timescale 1ns/1ns
`default_nettype none
`include "cfrs_defs.svh"
module cfrs_core (
  input  wire logic                core_clk,    // cpu clock
  input  wire logic                rst,         // async reset, high
  input  wire cfrs_pkg::cfrs_op_t  op,          // decoder operation
  input  wire logic [2:0]          bit_sel,     // bit for store/load
  input  wire logic [4:0]          rd_addr_a,   // operand a register
  input  wire logic [4:0]          rd_addr_b,   // operand b register
  input  wire logic                wr_en,       // result byte write
  input  wire logic [4:0]          wr_addr,     // result register
  input  wire logic [7:0]          wr_data,     // result byte
  input  wire logic                wr16_en,     // result pair write
  input  wire logic [4:0]          wr16_addr,   // result pair register
  input  wire logic [15:0]         wr16_data,   // result word
  input  wire logic [4:0]          flag_we,     // h v n z c update mask
  input  wire logic [7:0]          alu_res,     // alu result byte
  input  wire logic                alu_h,       // alu half carry
  input  wire logic                alu_v,       // alu overflow
  input  wire logic                alu_c,       // alu carry
  input  wire logic                irq_req,     // pending enabled irq
  input  wire logic                ptr_en,      // use a pointer address
  input  wire cfrs_pkg::cfrs_psel_t ptr_sel,    // pointer choice
  input  wire cfrs_pkg::cfrs_pmode_t ptr_mode,  // addressing mode
  input  wire logic [5:0]          ptr_disp,    // displacement
  input  wire logic                ds_re,       // data space read
  input  wire logic                ds_we,       // data space write
  input  wire logic                ds_io,       // address is io space
  input  wire logic [15:0]         ds_addr,     // direct address
  input  wire logic [7:0]          ds_wdata,    // write byte
  output logic [7:0]               rd_a_q,      // operand a
  output logic [7:0]               rd_b_q,      // operand b
  output logic [15:0]              rd16_q,      // pair operand at a
  output logic [7:0]               ds_rdata_q,  // data space read byte
  output logic [15:0]              ea_q,        // effective address
  output logic [7:0]               cpu_flag_register_q,      // flag register
  output logic [15:0]              sp_q,        // stack pointer
  output logic [15:0]              stk_addr_q,  // stack memory address
  output logic                     irq_grant_q  // interrupt taken
);
  import cfrs_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_rf(input logic [15:0] a);
    in_rf = (a <= `CFRS_RF_TOP);
  endfunction

  function automatic logic [15:0] sp_step(input logic [15:0] s,
                                           input logic [15:0] d,
                                           input logic        down);
    sp_step = (down ? s - d : s + d) & `CFRS_SP_MASK;
  endfunction

  cfrs_rf_if rf ();
  cfrs_regfile u_rf (.core_clk(core_clk), .rf(rf.store));

  // ----------------------------------------------------------------
  // indirect pointers
  // ----------------------------------------------------------------
  wire [15:0] ptr_val = (ptr_sel == PS_X) ? rf.px :
                        (ptr_sel == PS_Y) ? rf.py : rf.pz;
  wire [15:0] ptr_inc = ptr_val + `CFRS_ONE;
  wire [15:0] ptr_dec = ptr_val - `CFRS_ONE;
  wire [15:0] ptr_dsp = ptr_val + {10'h000, ptr_disp};
  // pre decrement addresses the new value, post increment the old one
  wire [15:0] ptr_ea  = (ptr_mode == PM_DEC)  ? ptr_dec :
                        (ptr_mode == PM_DISP) ? ptr_dsp : ptr_val;
  wire        ptr_upd = ptr_en && (ptr_mode != PM_DISP);
  wire [15:0] ptr_new = (ptr_mode == PM_INC) ? ptr_inc : ptr_dec;
  wire [4:0]  ptr_reg = (ptr_sel == PS_X) ? `CFRS_PTR_X :
                        (ptr_sel == PS_Y) ? `CFRS_PTR_Y : `CFRS_PTR_Z;

  // ----------------------------------------------------------------
  // data space decode
  // ----------------------------------------------------------------
  wire [15:0] dir_addr = ds_io ? ds_addr + `CFRS_IO_OFS : ds_addr;
  wire [15:0] eff      = ptr_en ? ptr_ea : dir_addr;
  wire        rf_hit   = in_rf(eff);
  wire        spl_hit  = (eff == `CFRS_A_SPL);
  wire        sph_hit  = (eff == `CFRS_A_SPH);
  wire        sr_hit   = (eff == `CFRS_A_CPU_FLAG_REGISTER);
  wire        sr_wr    = ds_we && sr_hit;

  // ----------------------------------------------------------------
  // register file ports
  // ----------------------------------------------------------------
  wire       is_bld  = (op == OP_BLD);
  wire [7:0] bit_one = 8'h01 << bit_sel;
  wire [7:0] bld_byte = cpu_flag_register_q[`CFRS_SR_T] ? (rf.da | bit_one)
                                           : (rf.da & ~bit_one);
  // one byte write port: decoder result beats bit load beats store
  assign rf.ra   = rd_addr_a;
  assign rf.rb   = rd_addr_b;
  assign rf.rc   = eff[4:0];
  assign rf.we   = wr_en || is_bld || (ds_we && rf_hit);
  assign rf.wa   = wr_en ? wr_addr : is_bld ? rd_addr_a : eff[4:0];
  assign rf.wd   = wr_en ? wr_data : is_bld ? bld_byte : ds_wdata;
  // pair port: decoder word result beats pointer write back
  assign rf.we16 = wr16_en || ptr_upd;
  assign rf.wa16 = wr16_en ? wr16_addr : ptr_reg;
  assign rf.wd16 = wr16_en ? wr16_data : ptr_new;

  // ----------------------------------------------------------------
  // interrupt grant and global enable
  // ----------------------------------------------------------------
  // grant only at an instruction boundary, so an OP_CLI in flight wins but a flag register store at an idle slot does not
  wire grant_d = irq_req && cpu_flag_register_q[`CFRS_SR_I] && (op == OP_NONE);
  wire [7:0] cpu_flag_register_d;
  assign cpu_flag_register_d[`CFRS_SR_I] = grant_d ? 1'b0 :
                              (op == OP_RETURN_FROM_INT_OP || op == OP_SEI) ? 1'b1 :
                              (op == OP_CLI) ? 1'b0 :
                              sr_wr ? ds_wdata[`CFRS_SR_I] : cpu_flag_register_q[`CFRS_SR_I];
  assign cpu_flag_register_d[`CFRS_SR_T] = (op == OP_BST) ? rf.da[bit_sel] :
                              sr_wr ? ds_wdata[`CFRS_SR_T] : cpu_flag_register_q[`CFRS_SR_T];

  // ----------------------------------------------------------------
  // arithmetic flags: an alu update beats a plain register write
  // ----------------------------------------------------------------
  assign cpu_flag_register_d[`CFRS_SR_H] = flag_we[`CFRS_FW_H] ? alu_h :
                              sr_wr ? ds_wdata[`CFRS_SR_H] : cpu_flag_register_q[`CFRS_SR_H];
  assign cpu_flag_register_d[`CFRS_SR_V] = flag_we[`CFRS_FW_V] ? alu_v :
                              sr_wr ? ds_wdata[`CFRS_SR_V] : cpu_flag_register_q[`CFRS_SR_V];
  assign cpu_flag_register_d[`CFRS_SR_N] = flag_we[`CFRS_FW_N] ? alu_res[`CFRS_MSB] :
                              sr_wr ? ds_wdata[`CFRS_SR_N] : cpu_flag_register_q[`CFRS_SR_N];
  assign cpu_flag_register_d[`CFRS_SR_Z] = flag_we[`CFRS_FW_Z] ? (alu_res == 8'h00) :
                              sr_wr ? ds_wdata[`CFRS_SR_Z] : cpu_flag_register_q[`CFRS_SR_Z];
  assign cpu_flag_register_d[`CFRS_SR_C] = flag_we[`CFRS_FW_C] ? alu_c :
                              sr_wr ? ds_wdata[`CFRS_SR_C] : cpu_flag_register_q[`CFRS_SR_C];
  // sign is derived, never stored apart, so it cannot drift from n and v
  assign cpu_flag_register_d[`CFRS_SR_S] = cpu_flag_register_d[`CFRS_SR_N] ^ cpu_flag_register_d[`CFRS_SR_V];

  // ----------------------------------------------------------------
  // stack pointer
  // ----------------------------------------------------------------
  wire down2 = grant_d || (op == OP_CALL);
  wire up2   = (op == OP_RET) || (op == OP_RETURN_FROM_INT_OP);
  wire pre_up = up2 || (op == OP_POP);
  wire [15:0] sp_d = down2 ? sp_step(sp_q, `CFRS_TWO, 1'b1) :
                     up2 ? sp_step(sp_q, `CFRS_TWO, 1'b0) :
                     (op == OP_PUSH) ? sp_step(sp_q, `CFRS_ONE, 1'b1) :
                     (op == OP_POP) ? sp_step(sp_q, `CFRS_ONE, 1'b0) :
                     (ds_we && spl_hit) ? {sp_q[15:8], ds_wdata} :
                     (ds_we && sph_hit) ? ({ds_wdata, sp_q[7:0]} & `CFRS_SP_MASK) :
                     sp_q;
  // push writes at the pointer, pop reads one above it
  wire [15:0] stk_d = pre_up ? sp_step(sp_q, `CFRS_ONE, 1'b0) :
                      (down2 || op == OP_PUSH) ? sp_q : stk_addr_q;

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  wire [7:0] ds_sel = rf_hit  ? rf.dc :
                      spl_hit ? sp_q[7:0] :
                      sph_hit ? sp_q[15:8] :
                      sr_hit  ? cpu_flag_register_q : 8'h00;
  wire [7:0] ds_rdata_d = ds_re ? ds_sel : ds_rdata_q;

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_flag_register_q      <= `CFRS_SR_RST;
      sp_q        <= `CFRS_SP_RST;
      stk_addr_q  <= `CFRS_SP_RST;
      irq_grant_q <= 1'b0;
    end else begin
      cpu_flag_register_q      <= cpu_flag_register_d;
      sp_q        <= sp_d;
      stk_addr_q  <= stk_d;
      irq_grant_q <= grant_d;
    end
  end

  // operand and address outputs, registered for timing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_a_q     <= '0;
      rd_b_q     <= '0;
      rd16_q     <= '0;
      ds_rdata_q <= '0;
      ea_q       <= '0;
    end else begin
      rd_a_q     <= rf.da;
      rd_b_q     <= rf.db;
      rd16_q     <= rf.d16;
      ds_rdata_q <= ds_rdata_d;
      ea_q       <= eff;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  wire       bst_bit = rf.da[bit_sel];
  wire [7:0] rf_dc   = rf.dc;
  wire       res_zero = (alu_res == 8'h00);
  wire       res_neg  = alu_res[`CFRS_MSB];

  sequence s_gie_off;
    !cpu_flag_register_q[`CFRS_SR_I];
  endsequence
  sequence s_push;
    op == OP_PUSH;
  endsequence
  sequence s_call;
    op == OP_CALL;
  endsequence

  gie_blocks_irq_a: assert property (s_gie_off |=> !irq_grant_q)
    else $error("interrupt granted with global enable clear");
  grant_clears_gie_a: assert property (
    irq_grant_q |-> !cpu_flag_register_q[`CFRS_SR_I] ##1 !irq_grant_q)
    else $error("grant left global enable set");
  return_from_int_op_sets_gie_a: assert property (
    (op == OP_RETURN_FROM_INT_OP) |=> cpu_flag_register_q[`CFRS_SR_I] && sp_q == sp_step($past(sp_q), `CFRS_TWO, 1'b0))
    else $error("interrupt return did not restore enable and pointer");
  cli_clears_gie_a: assert property ((op == OP_CLI) |=> !cpu_flag_register_q[`CFRS_SR_I] && !irq_grant_q)
    else $error("clear interrupt op left enable set");
  bst_copy_bit_a: assert property (
    (op == OP_BST) |=> cpu_flag_register_q[`CFRS_SR_T] == $past(bst_bit))
    else $error("bit store copied the wrong bit");
  sign_xor_nv_a: assert property (
    cpu_flag_register_q[`CFRS_SR_S] == (cpu_flag_register_q[`CFRS_SR_N] ^ cpu_flag_register_q[`CFRS_SR_V]))
    else $error("sign bit differs from n xor v");
  zero_flag_a: assert property (
    flag_we[`CFRS_FW_Z] |=> cpu_flag_register_q[`CFRS_SR_Z] == $past(res_zero))
    else $error("zero bit wrong after alu update");
  reg_map_read_a: assert property ((ds_re && rf_hit) |=> ds_rdata_q == $past(rf_dc))
    else $error("data space read missed the register file");
  push_dec_one_a: assert property (
    s_push |=> sp_q == sp_step($past(sp_q), `CFRS_ONE, 1'b1) && stk_addr_q == $past(sp_q))
    else $error("push did not use then decrement pointer");
  call_dec_two_a: assert property (
    s_call |=> sp_q == sp_step($past(sp_q), `CFRS_TWO, 1'b1))
    else $error("call did not decrement pointer by two");
  sp_top_zero_a: assert property ((sp_q & ~`CFRS_SP_MASK) == 16'h0000)
    else $error("stack pointer upper bits not zero");
  grant_idle_only_a: assert property (
    irq_grant_q |-> $past(op) == OP_NONE && $past(irq_req))
    else $error("interrupt granted outside an idle decoder slot");
  grant_sp_two_a: assert property (
    irq_grant_q |-> sp_q == sp_step($past(sp_q), `CFRS_TWO, 1'b1) && stk_addr_q == $past(sp_q))
    else $error("interrupt entry did not move pointer by two");
  sei_sets_gie_a: assert property ((op == OP_SEI) |=> cpu_flag_register_q[`CFRS_SR_I])
    else $error("set interrupt op left enable clear");
  pop_inc_one_a: assert property (
    (op == OP_POP) |=> sp_q == sp_step($past(sp_q), `CFRS_ONE, 1'b0) && stk_addr_q == sp_q)
    else $error("pop did not increment then read");
  ret_inc_two_a: assert property (
    (op == OP_RET) |=> sp_q == sp_step($past(sp_q), `CFRS_TWO, 1'b0))
    else $error("return did not increment pointer by two");
  sp_low_write_a: assert property (
    (ds_we && spl_hit && op == OP_NONE && !grant_d) |=> sp_q[7:0] == $past(ds_wdata))
    else $error("stack low byte write lost");
  half_carry_a: assert property (
    flag_we[`CFRS_FW_H] |=> cpu_flag_register_q[`CFRS_SR_H] == $past(alu_h))
    else $error("half carry bit wrong after alu update");
  neg_flag_a: assert property (
    flag_we[`CFRS_FW_N] |=> cpu_flag_register_q[`CFRS_SR_N] == $past(res_neg))
    else $error("negative bit wrong after alu update");
  carry_flag_a: assert property (
    flag_we[`CFRS_FW_C] |=> cpu_flag_register_q[`CFRS_SR_C] == $past(alu_c))
    else $error("carry bit wrong after alu update");
  ovf_flag_a: assert property (
    flag_we[`CFRS_FW_V] |=> cpu_flag_register_q[`CFRS_SR_V] == $past(alu_v))
    else $error("overflow bit wrong after alu update");

endmodule // cfrs_core
`default_nettype wire

// ===== bench/cfrs_irq_model.sv
// interrupt source model that stands beside the core
`timescale 1ns/1ns
`default_nettype none
module cfrs_irq_model (
  input  wire logic core_clk,    // cpu clock
  input  wire logic rst,         // async reset, high
  input  wire logic fire,        // raise a request
  input  wire logic irq_grant_q, // core took the request
  output var  logic irq_req      // pending request
);
  // level source: stays pending until granted, so a masked request is not lost
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_req <= 1'b0;
    end else if (irq_grant_q) begin
      irq_req <= 1'b0;
    end else if (fire) begin
      irq_req <= 1'b1;
    end
  end
endmodule // cfrs_irq_model
`default_nettype wire

// ===== bench/cpu_flags_regfile_stack_ptr_tb.sv
// self-checking testbench of the flag, register file and stack pointer core
`timescale 1ns/1ns
`default_nettype none
module cpu_flags_regfile_stack_ptr_tb;
  import cfrs_pkg::*;
  logic        core_clk, rst, wr_en, wr16_en, alu_h, alu_v, alu_c, irq_req, fire, ptr_en, ds_re, ds_we, ds_io;
  logic [2:0]  bit_sel;
  logic [4:0]  rd_addr_a, rd_addr_b, wr_addr, wr16_addr, flag_we;
  logic [5:0]  ptr_disp;
  logic [7:0]  wr_data, alu_res, ds_wdata, rd_a_q, rd_b_q, ds_rdata_q, cpu_flag_register_q;
  logic [15:0] wr16_data, ds_addr, rd16_q, ea_q, sp_q, stk_addr_q;
  logic        irq_grant_q;
  cfrs_op_t    op;
  cfrs_psel_t  ptr_sel;
  cfrs_pmode_t ptr_mode;
  int          fail_count = 0;
  int          comparisons = 0;

  cfrs_core u_dut (
    .core_clk(core_clk), .rst(rst), .op(op), .bit_sel(bit_sel),
    .rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr16_en(wr16_en), .wr16_addr(wr16_addr), .wr16_data(wr16_data),
    .flag_we(flag_we), .alu_res(alu_res), .alu_h(alu_h), .alu_v(alu_v), .alu_c(alu_c),
    .irq_req(irq_req), .ptr_en(ptr_en), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode), .ptr_disp(ptr_disp),
    .ds_re(ds_re), .ds_we(ds_we), .ds_io(ds_io), .ds_addr(ds_addr), .ds_wdata(ds_wdata),
    .rd_a_q(rd_a_q), .rd_b_q(rd_b_q), .rd16_q(rd16_q), .ds_rdata_q(ds_rdata_q), .ea_q(ea_q),
    .cpu_flag_register_q(cpu_flag_register_q), .sp_q(sp_q), .stk_addr_q(stk_addr_q), .irq_grant_q(irq_grant_q)
  );
  cfrs_irq_model u_irq (
    .core_clk(core_clk), .rst(rst), .fire(fire), .irq_grant_q(irq_grant_q), .irq_req(irq_req)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one decoder operation, held for exactly one edge, then an idle edge
  task automatic do_op(input cfrs_op_t o);
    op = o;
    @(negedge core_clk);
    op = OP_NONE;
    @(negedge core_clk);
  endtask
  task automatic ds_acc(input logic we, input logic io, input logic [15:0] a, input logic [7:0] d);
    ds_we = we;
    ds_re = ~we;
    ds_io = io;
    ds_addr = a;
    ds_wdata = d;
    @(negedge core_clk);
    ds_we = 1'b0;
    ds_re = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge core_clk);
    wr_en = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic wr16(input logic [4:0] a, input logic [15:0] d);
    wr16_en = 1'b1;
    wr16_addr = a;
    wr16_data = d;
    @(negedge core_clk);
    wr16_en = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [4:0] b);
    rd_addr_a = a;
    rd_addr_b = b;
    @(negedge core_clk);
  endtask
  task automatic pread(input cfrs_psel_t s, input cfrs_pmode_t m, input logic [5:0] dsp,
                       input logic [15:0] ea, input logic [7:0] d);
    ptr_en = 1'b1;
    ptr_sel = s;
    ptr_mode = m;
    ptr_disp = dsp;
    ds_io = 1'b0;
    ds_addr = 16'h0000;
    ds_re = 1'b1;
    @(negedge core_clk);
    ptr_en = 1'b0;
    ds_re = 1'b0;
    // effective address stands for one cycle only, so look before the idle edge
    chk("pointer address", ea, ea_q);
    chk("pointer data", {8'h00, d}, {8'h00, ds_rdata_q});
    @(negedge core_clk);
  endtask
  task automatic flags(input logic [7:0] res, input logic h, input logic v, input logic c, input logic [7:0] exp);
    flag_we = 5'h1f;
    alu_res = res;
    alu_h = h;
    alu_v = v;
    alu_c = c;
    @(negedge core_clk);
    flag_we = 5'h00;
    chk("alu flags", {8'h00, exp}, {8'h00, cpu_flag_register_q});
    @(negedge core_clk);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // all tests need under 250 cycles; a hang is cut well beyond that
  initial begin
    repeat (2000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end
  initial begin
    {wr_en, wr16_en, alu_h, alu_v, alu_c, fire, ptr_en, ds_re, ds_we, ds_io} = '0;
    {bit_sel, rd_addr_a, rd_addr_b, wr_addr, wr_data, wr16_addr, wr16_data} = '0;
    {flag_we, alu_res, ptr_disp, ds_addr, ds_wdata} = '0;
    op = OP_NONE;
    ptr_sel = PS_X;
    ptr_mode = PM_DISP;
    rst = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    chk("flags at reset", 16'h0000, {8'h00, cpu_flag_register_q});
    chk("stack pointer at reset", 16'h04ff, sp_q);
    ds_acc(1'b0, 1'b0, 16'h005d, 8'h00);
    chk("stack low read", 16'h00ff, {8'h00, ds_rdata_q});
    ds_acc(1'b0, 1'b1, 16'h003e, 8'h00);
    chk("stack high io read", 16'h0004, {8'h00, ds_rdata_q});
    ds_acc(1'b0, 1'b0, 16'h0060, 8'h00);
    chk("unmapped read", 16'h0000, {8'h00, ds_rdata_q});
    $display("test reset and map done");
    // stack placed before any call or interrupt enable
    ds_acc(1'b1, 1'b0, 16'h005d, 8'h00);
    ds_acc(1'b1, 1'b1, 16'h003e, 8'h03);
    chk("stack after writes", 16'h0300, sp_q);
    do_op(OP_PUSH);
    chk("push pointer", 16'h02ff, sp_q);
    chk("push address", 16'h0300, stk_addr_q);
    do_op(OP_POP);
    chk("pop pointer", 16'h0300, sp_q);
    chk("pop address", 16'h0300, stk_addr_q);
    do_op(OP_CALL);
    chk("call pointer", 16'h02fe, sp_q);
    chk("call address", 16'h0300, stk_addr_q);
    do_op(OP_RET);
    chk("return pointer", 16'h0300, sp_q);
    chk("return address", 16'h02ff, stk_addr_q);
    ds_acc(1'b1, 1'b0, 16'h005e, 8'hff);
    chk("upper bits dropped", 16'h0f00, sp_q);
    ds_acc(1'b0, 1'b0, 16'h005e, 8'h00);
    chk("high byte read", 16'h000f, {8'h00, ds_rdata_q});
    ds_acc(1'b1, 1'b0, 16'h005e, 8'h03);
    $display("test stack done");
    fire = 1'b1;
    @(negedge core_clk);
    fire = 1'b0;
    repeat (3) begin
      @(negedge core_clk);
      chk("grant while masked", 16'h0000, {15'h0000, irq_grant_q});
    end
    // inline, so the enable is seen before the pending request is taken
    op = OP_SEI;
    @(negedge core_clk);
    op = OP_NONE;
    chk("enable set", 16'h0001, {15'h0000, cpu_flag_register_q[7]});
    @(negedge core_clk);
    chk("grant", 16'h0001, {15'h0000, irq_grant_q});
    chk("enable cleared", 16'h0000, {15'h0000, cpu_flag_register_q[7]});
    chk("entry pointer", 16'h02fe, sp_q);
    @(negedge core_clk);
    chk("grant ends", 16'h0000, {15'h0000, irq_grant_q});
    do_op(OP_RETURN_FROM_INT_OP);
    chk("enable restored", 16'h0001, {15'h0000, cpu_flag_register_q[7]});
    chk("interrupt return pointer", 16'h0300, sp_q);
    do_op(OP_CLI);
    chk("enable cleared by op", 16'h0000, {15'h0000, cpu_flag_register_q[7]});
    $display("test interrupt done");
    // written sign bit is replaced by negative xor overflow
    ds_acc(1'b1, 1'b0, 16'h005f, 8'ha5);
    chk("flag write", 16'h00b5, {8'h00, cpu_flag_register_q});
    flags(8'h80, 1'b1, 1'b1, 1'b0, 8'hac);
    flags(8'h00, 1'b0, 1'b0, 1'b1, 8'h83);
    ds_acc(1'b0, 1'b1, 16'h003f, 8'h00);
    chk("flag io read", 16'h0083, {8'h00, ds_rdata_q});
    $display("test flags done");
    wr(5'd5, 8'h3c);
    wr(5'd6, 8'h00);
    rd_addr_a = 5'd5;
    bit_sel = 3'd2;
    do_op(OP_BST);
    chk("copy bit stored", 16'h0001, {15'h0000, cpu_flag_register_q[6]});
    rd_addr_a = 5'd6;
    bit_sel = 3'd7;
    do_op(OP_BLD);
    rd(5'd6, 5'd5);
    chk("copy bit loaded", 16'h0080, {8'h00, rd_a_q});
    $display("test bit copy done");
    wr(5'd3, 8'h5a);
    wr16(5'd30, 16'h0003);
    pread(PS_Z, PM_INC, 6'd0, 16'h0003, 8'h5a);
    rd(5'd30, 5'd5);
    chk("pointer incremented", 16'h0004, rd16_q);
    pread(PS_Z, PM_DEC, 6'd0, 16'h0003, 8'h5a);
    pread(PS_Z, PM_DISP, 6'd2, 16'h0005, 8'h3c);
    rd(5'd30, 5'd5);
    chk("pointer kept", 16'h0003, rd16_q);
    wr16(5'd26, 16'h1234);
    rd(5'd26, 5'd5);
    chk("pair read", 16'h1234, rd16_q);
    chk("second operand", 16'h003c, {8'h00, rd_b_q});
    ds_acc(1'b0, 1'b0, 16'h001b, 8'h00);
    chk("odd register is high", 16'h0012, {8'h00, ds_rdata_q});
    ds_acc(1'b1, 1'b0, 16'h0007, 8'h77);
    rd(5'd7, 5'd5);
    chk("store into register", 16'h0077, {8'h00, rd_a_q});
    wr16(5'd28, 16'h0005);
    pread(PS_Y, PM_DISP, 6'd0, 16'h0005, 8'h3c);
    wr16(5'd26, 16'h0003);
    pread(PS_X, PM_INC, 6'd0, 16'h0003, 8'h5a);
    rd(5'd26, 5'd5);
    chk("x pointer incremented", 16'h0004, rd16_q);
    $display("test register file done");
    print_verdict();
  end
endmodule // cpu_flags_regfile_stack_ptr_tb
`default_nettype wire
